// [hw/interrupt_vector_resolver.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Overview of operation
// R01: software interrupt instruction accepts numbers 0 to 63 and raises that one
// R02: software numbers 3 to 31 share relocatable entries with peripherals
// R03: numbers 0 to 31 push the stack-select flag, then clear it
// R04: return from interrupt restores the stack-select flag from the stack
// R05: numbers 32 to 63 leave the stack-select flag alone
// R06: special interrupts ignore the interrupt enable flag
// R07: watchdog, oscillation stop and both voltage monitors share slot 0FFF0h
// R08: enabled address match raises an interrupt before that instruction runs
// R09: peripheral interrupts need the enable flag and a higher priority level
// R10: each vector entry is four bytes holding the handler address
// R11: after acknowledge the program counter loads from the entry
// R12: fixed table 0FFDCh to 0FFFFh, nine slots in documented order
// R13: break uses the relocatable entry when byte 0FFE7h reads FFh
// R14: upper vector bytes double as flash id code bytes
// R15: software must not use single-step or address break sources
// R16: relocatable table is 256 bytes, entry n at base plus 4n
// R17: vector bytes are fetched lowest address first, least significant first
module interrupt_vector_resolver (
  // clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        NRST_I,
  // register port
  input  wire logic [2:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [31:0] REG_RDATA_O,
  // instruction traps from the core
  input  wire logic        SWI_REQ_I,
  input  wire logic [5:0]  SWI_NUM_I,
  input  wire logic        UNDEFINED_OPCODE_OP_I,
  input  wire logic        OVERFLOW_TRAP_OP_I,
  input  wire logic        OVF_FLAG_I,
  input  wire logic        BREAK_OP_I,
  // special sources
  input  wire logic        WDOG_I,
  input  wire logic        OSC_STOP_I,
  input  wire logic        VMON1_I,
  input  wire logic        VMON2_I,
  input  wire logic        SSTEP_I,
  input  wire logic        ABREAK_I,
  // peripheral request
  input  wire logic        PER_REQ_I,
  input  wire logic [5:0]  PER_NUM_I,
  input  wire logic [2:0]  PER_LEVEL_I,
  input  wire logic        IFLAG_I,
  input  wire logic [2:0]  IPL_I,
  output logic             PER_ACK_O,
  // instruction about to execute
  input  wire logic        EXEC_VALID_I,
  input  wire logic [19:0] EXEC_ADDR_I,
  // stack-select flag
  input  wire logic        UFLAG_WR_I,
  input  wire logic        UFLAG_WDATA_I,
  input  wire logic        RETI_I,
  input  wire logic        RETI_UFLAG_I,
  output logic             UFLAG_O,
  output logic             UFLAG_PUSH_O,
  output logic             UFLAG_PUSH_VAL_O,
  // vector memory
  output logic             MEM_RD_O,
  output logic      [19:0] MEM_ADDR_O,
  input  wire logic [7:0]  MEM_DATA_I,
  // program counter handoff
  output logic             BUSY_O,
  output logic             PC_LOAD_O,
  output logic      [19:0] PC_O
);

  vec_fetch_if vf ();

  ivr_pkg::main_state_t   state_q;
  logic [19:0]            match_address_reg0_q;
  logic [19:0]            match_address_reg1_q;
  logic [1:0]             match_enable_reg_q;
  logic [19:0]            vector_table_base_q;
  logic [19:0]            mad [2];
  logic [1:0]             hit;
  logic                   match_pend_q;
  logic [ivr_pkg::SP_W-1:0] pend_q;
  logic [ivr_pkg::SP_W-1:0] src;
  logic                   u_q;
  logic                   push_q;
  logic                   push_val_q;
  logic                   start_q;
  logic                   brk_q;
  logic [19:0]            vec_q;
  logic                   pc_load_q;
  logic [19:0]            pc_q;
  logic                   per_ack_q;
  logic [31:0]            rdata_q;
  logic [31:0]            status_w;
  logic                   instr_req;
  logic                   per_ok;
  logic                   take;
  logic                   sel_valid;
  logic                   sel_brk;
  logic                   sel_push;
  logic                   sel_swi;
  logic                   sel_per;
  logic                   sel_match;
  logic [ivr_pkg::SP_W-1:0] sel_clr;
  logic [19:0]            sel_vec;
  logic [19:0]            swi_entry;
  logic [19:0]            per_entry;

  // ========================================================================
  // outputs
  assign REG_RDATA_O      = rdata_q;
  assign UFLAG_O          = u_q;
  assign UFLAG_PUSH_O     = push_q;
  assign UFLAG_PUSH_VAL_O = push_val_q;
  assign MEM_RD_O         = vf.mem_rd;
  assign MEM_ADDR_O       = vf.mem_addr;
  assign BUSY_O           = (state_q != ivr_pkg::M_IDLE);
  assign PC_LOAD_O        = pc_load_q;
  assign PC_O             = pc_q;
  assign PER_ACK_O        = per_ack_q;

  assign vf.start      = start_q;
  assign vf.brk_chk    = brk_q;
  assign vf.vec_addr   = vec_q;
  assign vf.reloc_base = vector_table_base_q;
  assign vf.mem_data   = MEM_DATA_I;

  // ========================================================================
  // address match comparators
  assign mad[0] = match_address_reg0_q;
  assign mad[1] = match_address_reg1_q;

  for (genvar c = 0; c < 2; c++) begin : g_match
    assign hit[c] = match_enable_reg_q[c] && (EXEC_ADDR_I == mad[c]); // [R08]
  end

  // ========================================================================
  // source selection
  assign swi_entry = vector_table_base_q + {12'h000, SWI_NUM_I, 2'b00}; // [R16] [R01]
  assign per_entry = vector_table_base_q + {12'h000, PER_NUM_I, 2'b00}; // [R02] [R16]
  assign instr_req = UNDEFINED_OPCODE_OP_I || (OVERFLOW_TRAP_OP_I && OVF_FLAG_I)
                  || BREAK_OP_I || SWI_REQ_I;
  assign per_ok    = PER_REQ_I && IFLAG_I && (PER_LEVEL_I > IPL_I); // [R09]

  // instruction traps first, since the core stalls on them; specials
  // never look at the enable flag
  always_comb begin
    sel_valid = 1'b1;
    sel_vec   = ivr_pkg::VEC_UNDEF;
    sel_brk   = 1'b0;
    sel_push  = 1'b1;
    sel_swi   = 1'b0;
    sel_per   = 1'b0;
    sel_match = 1'b0;
    sel_clr   = '0;
    if (UNDEFINED_OPCODE_OP_I) begin
      sel_vec = ivr_pkg::VEC_UNDEF; // [R12]
    end else if (OVERFLOW_TRAP_OP_I && OVF_FLAG_I) begin
      sel_vec = ivr_pkg::VEC_OVF; // [R12]
    end else if (BREAK_OP_I) begin
      sel_vec = ivr_pkg::VEC_BREAK; // [R12]
      sel_brk = 1'b1; // [R13]
    end else if (SWI_REQ_I) begin
      sel_vec  = swi_entry; // [R01] [R02]
      sel_swi  = 1'b1;
      sel_push = (SWI_NUM_I <= ivr_pkg::SWI_USTACK_LAST); // [R03] [R05]
    end else if (match_pend_q) begin
      sel_vec   = ivr_pkg::VEC_AMATCH; // [R06]
      sel_match = 1'b1;
    end else if (|pend_q[ivr_pkg::SP_VMON2:ivr_pkg::SP_WDOG]) begin
      sel_vec = ivr_pkg::VEC_SPECIAL; // [R07] [R06]
      sel_clr[ivr_pkg::SP_VMON2:ivr_pkg::SP_WDOG] = 4'hf;
    end else if (pend_q[ivr_pkg::SP_SSTEP]) begin
      sel_vec = ivr_pkg::VEC_SSTEP; // [R06]
      sel_clr[ivr_pkg::SP_SSTEP] = 1'b1;
    end else if (pend_q[ivr_pkg::SP_ABRK]) begin
      sel_vec = ivr_pkg::VEC_ABREAK; // [R06]
      sel_clr[ivr_pkg::SP_ABRK] = 1'b1;
    end else if (per_ok) begin
      sel_vec = per_entry; // [R09]
      sel_per = 1'b1;
    end else begin
      sel_valid = 1'b0;
    end
  end

  assign take = (state_q == ivr_pkg::M_IDLE) && sel_valid;

  // ========================================================================
  // pending special sources; a new event beats the clear
  assign src = {ABREAK_I, SSTEP_I, VMON2_I, VMON1_I, OSC_STOP_I, WDOG_I};

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~(take ? sel_clr : '0)) | src; // [R06]
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      match_pend_q <= 1'b0;
    end else if (EXEC_VALID_I && |hit) begin
      match_pend_q <= 1'b1; // [R08]
    end else if (take && sel_match) begin
      match_pend_q <= 1'b0;
    end
  end

  // ========================================================================
  // sequencing
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_q   <= ivr_pkg::M_IDLE;
      start_q   <= 1'b0;
      brk_q     <= 1'b0;
      vec_q     <= 20'h00000;
      pc_load_q <= 1'b0;
      pc_q      <= 20'h00000;
      per_ack_q <= 1'b0;
    end else begin
      start_q   <= 1'b0;
      pc_load_q <= 1'b0;
      per_ack_q <= 1'b0;
      case (state_q)
        ivr_pkg::M_IDLE: begin
          if (take) begin
            state_q   <= ivr_pkg::M_WAIT;
            start_q   <= 1'b1;
            brk_q     <= sel_brk;
            vec_q     <= sel_vec;
            per_ack_q <= sel_per;
          end
        end
        ivr_pkg::M_WAIT: begin
          if (vf.done) begin
            state_q   <= ivr_pkg::M_IDLE;
            pc_load_q <= 1'b1; // [R11]
            pc_q      <= vf.handler; // [R11]
          end
        end
        default: begin
          state_q <= ivr_pkg::M_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // stack-select flag
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      u_q        <= ivr_pkg::UFLAG_RST;
      push_q     <= 1'b0;
      push_val_q <= 1'b0;
    end else begin
      push_q     <= take && sel_push; // [R03]
      push_val_q <= u_q;
      if (take && sel_push) begin
        u_q <= 1'b0; // [R03]
      end else if (RETI_I) begin
        u_q <= RETI_UFLAG_I; // [R04]
      end else if (UFLAG_WR_I) begin
        u_q <= UFLAG_WDATA_I;
      end
    end
  end

  // ========================================================================
  // register port
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      match_address_reg0_q <= ivr_pkg::MATCH_RST;
      match_address_reg1_q <= ivr_pkg::MATCH_RST;
      match_enable_reg_q   <= ivr_pkg::MATCH_EN_RST;
      vector_table_base_q  <= ivr_pkg::VEC_BASE_RST;
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        ivr_pkg::REG_MATCH0:   match_address_reg0_q <= REG_WDATA_I[19:0];
        ivr_pkg::REG_MATCH1:   match_address_reg1_q <= REG_WDATA_I[19:0];
        ivr_pkg::REG_MATCH_EN: match_enable_reg_q   <= REG_WDATA_I[1:0];
        ivr_pkg::REG_VEC_BASE: vector_table_base_q  <= REG_WDATA_I[19:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    status_w = '0;
    status_w[ivr_pkg::ST_UFLAG] = u_q;
    status_w[ivr_pkg::ST_BUSY]  = BUSY_O;
    status_w[ivr_pkg::ST_MATCH] = match_pend_q;
    status_w[ivr_pkg::ST_PEND_LSB +: ivr_pkg::SP_W] = pend_q;
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_q <= 32'h00000000;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        ivr_pkg::REG_MATCH0:   rdata_q <= {12'h000, match_address_reg0_q};
        ivr_pkg::REG_MATCH1:   rdata_q <= {12'h000, match_address_reg1_q};
        ivr_pkg::REG_MATCH_EN: rdata_q <= {30'h00000000, match_enable_reg_q};
        ivr_pkg::REG_VEC_BASE: rdata_q <= {12'h000, vector_table_base_q};
        ivr_pkg::REG_STATUS:   rdata_q <= status_w;
        ivr_pkg::REG_HANDLER:  rdata_q <= {12'h000, pc_q};
        default:               rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  // ========================================================================
  // vector fetch
  vector_fetch_unit u_fetch (
    .clk_i  (CLOCK_I),
    .rst_ni (NRST_I),
    .vf     (vf.fetcher)
  );

  // ========================================================================
  // checks
  chk_swi_stack_save: assert property ( // [R03]
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (take && sel_swi && SWI_NUM_I <= ivr_pkg::SWI_USTACK_LAST)
      |=> (!u_q && push_q && push_val_q == $past(u_q)))
    else $error("low software number did not save and clear flag");

  chk_swi_stack_keep: assert property ( // [R05]
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (take && sel_swi && SWI_NUM_I > ivr_pkg::SWI_USTACK_LAST && !RETI_I && !UFLAG_WR_I)
      |=> (u_q == $past(u_q) && !push_q))
    else $error("high software number touched the flag");

  chk_reti_restore: assert property ( // [R04]
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (RETI_I && !(take && sel_push)) |=> (u_q == $past(RETI_UFLAG_I)))
    else $error("flag not restored on return");

  chk_swi_entry: assert property ( // [R01]
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (take && sel_swi)
      |=> (start_q && !brk_q && vec_q == $past(vector_table_base_q) + {$past(SWI_NUM_I), 2'b00}))
    else $error("software interrupt entry address wrong");

  chk_special_slot: assert property ( // [R07]
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (state_q == ivr_pkg::M_IDLE && !instr_req && !match_pend_q && |pend_q[3:0])
      |=> (start_q && vec_q == ivr_pkg::VEC_SPECIAL && pend_q[3:0] == $past(src[3:0])))
    else $error("shared special slot not taken regardless of enable");

  chk_mask_gate: assert property ( // [R09]
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (take && sel_per) |-> (IFLAG_I && PER_LEVEL_I > IPL_I) ##1 per_ack_q)
    else $error("peripheral taken while masked");

  chk_match_raise: assert property ( // [R08]
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (EXEC_VALID_I && match_enable_reg_q[0] && EXEC_ADDR_I == match_address_reg0_q)
      |=> match_pend_q)
    else $error("address match not raised");

  chk_pc_handoff: assert property ( // [R11]
    @(posedge CLOCK_I) disable iff (!NRST_I)
    vf.done |=> (PC_LOAD_O && PC_O == $past(vf.handler) && !BUSY_O))
    else $error("program counter not loaded from entry");

  chk_break_fixed: assert property ( // [R12]
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (take && !UNDEFINED_OPCODE_OP_I && !(OVERFLOW_TRAP_OP_I && OVF_FLAG_I) && BREAK_OP_I)
      |=> (brk_q && vec_q == ivr_pkg::VEC_BREAK))
    else $error("break slot wrong");

endmodule // interrupt_vector_resolver
`default_nettype wire

// [hw/ivr_pkg.sv]
`default_nettype none
// ==========================================================================
// shared constants and types
package ivr_pkg;

  localparam int unsigned ADDR_W = 20;

  // fixed vector slots, four bytes each, lowest address first
  localparam logic [19:0] VEC_UNDEF   = 20'h0ffdc;
  localparam logic [19:0] VEC_OVF     = 20'h0ffe0;
  localparam logic [19:0] VEC_BREAK   = 20'h0ffe4;
  localparam logic [19:0] VEC_AMATCH  = 20'h0ffe8;
  localparam logic [19:0] VEC_SSTEP   = 20'h0ffec;
  localparam logic [19:0] VEC_SPECIAL = 20'h0fff0;
  localparam logic [19:0] VEC_ABREAK  = 20'h0fff4;
  localparam logic [19:0] VEC_RESET   = 20'h0fffc;

  // break redirection probe
  localparam logic [19:0] BRK_MARK_ADDR  = 20'h0ffe7;
  localparam logic [7:0]  BRK_RELOC_MARK = 8'hff;

  // software numbers 0..31 save and clear the stack-select flag
  localparam logic [5:0] SWI_USTACK_LAST = 6'h1f;
  // last byte index of a vector entry
  localparam logic [1:0] VEC_BYTE_LAST   = 2'h3;

  // register offsets
  localparam logic [2:0] REG_MATCH0   = 3'h0;
  localparam logic [2:0] REG_MATCH1   = 3'h1;
  localparam logic [2:0] REG_MATCH_EN = 3'h2;
  localparam logic [2:0] REG_VEC_BASE = 3'h3;
  localparam logic [2:0] REG_STATUS   = 3'h4;
  localparam logic [2:0] REG_HANDLER  = 3'h5;

  // reset values
  localparam logic [19:0] MATCH_RST    = 20'h00000;
  localparam logic [1:0]  MATCH_EN_RST = 2'h0;
  localparam logic [19:0] VEC_BASE_RST = 20'h00000;
  localparam logic        UFLAG_RST    = 1'b0;

  // status word fields
  localparam int unsigned ST_UFLAG    = 0;
  localparam int unsigned ST_BUSY     = 1;
  localparam int unsigned ST_MATCH    = 2;
  localparam int unsigned ST_PEND_LSB = 3;

  // special pending bits
  localparam int unsigned SP_WDOG  = 0;
  localparam int unsigned SP_OSC   = 1;
  localparam int unsigned SP_VMON1 = 2;
  localparam int unsigned SP_VMON2 = 3;
  localparam int unsigned SP_SSTEP = 4;
  localparam int unsigned SP_ABRK  = 5;
  localparam int unsigned SP_W     = 6;

  typedef enum logic [1:0] {M_IDLE, M_WAIT} main_state_t;
  typedef enum logic [1:0] {F_IDLE, F_CHECK, F_BYTES} fetch_state_t;

endpackage
`default_nettype wire

// [hw/vec_fetch_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// resolver to vector fetch unit
interface vec_fetch_if;
  logic        start;
  logic        brk_chk;
  logic [19:0] vec_addr;
  logic [19:0] reloc_base;
  logic        done;
  logic [19:0] handler;
  logic        mem_rd;
  logic [19:0] mem_addr;
  logic [7:0]  mem_data;

  modport requester (
    output start, brk_chk, vec_addr, reloc_base, mem_data,
    input  done, handler, mem_rd, mem_addr
  );
  modport fetcher (
    input  start, brk_chk, vec_addr, reloc_base, mem_data,
    output done, handler, mem_rd, mem_addr
  );
endinterface // vec_fetch_if
`default_nettype wire

// [hw/vector_fetch_unit.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// reads one vector entry byte by byte
module vector_fetch_unit (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_ni,
  // resolver side
  vec_fetch_if.fetcher   vf
);

  ivr_pkg::fetch_state_t state_q;
  logic                  rd_q;
  logic                  pend_q;
  logic [19:0]           addr_q;
  logic [19:0]           target_q;
  logic [1:0]            cnt_q;
  logic [7:0]            vbyte_q [3];
  logic                  done_q;
  logic [19:0]           handler_q;

  assign vf.mem_rd   = rd_q;
  assign vf.mem_addr = addr_q;
  assign vf.done     = done_q;
  assign vf.handler  = handler_q;

  // memory answers one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= rd_q;
    end
  end

  // one read at a time: simpler than pipelining, costs three idle cycles
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      state_q  <= ivr_pkg::F_IDLE;
      rd_q     <= 1'b0;
      addr_q   <= 20'h00000;
      target_q <= 20'h00000;
      cnt_q    <= 2'h0;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      rd_q   <= 1'b0;
      case (state_q)
        ivr_pkg::F_IDLE: begin
          if (vf.start) begin
            rd_q     <= 1'b1;
            cnt_q    <= 2'h0;
            target_q <= vf.vec_addr;
            if (vf.brk_chk) begin
              state_q <= ivr_pkg::F_CHECK;
              addr_q  <= ivr_pkg::BRK_MARK_ADDR; // [R13]
            end else begin
              state_q <= ivr_pkg::F_BYTES;
              addr_q  <= vf.vec_addr;
            end
          end
        end
        ivr_pkg::F_CHECK: begin
          if (pend_q) begin
            state_q <= ivr_pkg::F_BYTES;
            rd_q    <= 1'b1;
            if (vf.mem_data == ivr_pkg::BRK_RELOC_MARK) begin
              addr_q <= vf.reloc_base; // [R13] [R16]
            end else begin
              addr_q <= target_q;
            end
          end
        end
        ivr_pkg::F_BYTES: begin
          if (pend_q) begin
            cnt_q <= cnt_q + 2'h1;
            if (cnt_q == ivr_pkg::VEC_BYTE_LAST) begin // [R10]
              state_q <= ivr_pkg::F_IDLE;
              done_q  <= 1'b1;
            end else begin
              rd_q   <= 1'b1;
              addr_q <= addr_q + 20'h00001;
            end
          end
        end
        default: begin
          state_q <= ivr_pkg::F_IDLE;
        end
      endcase
    end
  end

  // lowest address is the least significant byte; the top byte is left
  // to the flash id check and never reaches the program counter
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      vbyte_q[0] <= 8'h00;
      vbyte_q[1] <= 8'h00;
      vbyte_q[2] <= 8'h00;
      handler_q  <= 20'h00000;
    end else if (state_q == ivr_pkg::F_BYTES && pend_q) begin
      if (cnt_q == ivr_pkg::VEC_BYTE_LAST) begin
        handler_q <= {vbyte_q[2][3:0], vbyte_q[1], vbyte_q[0]}; // [R17] [R14]
      end else begin
        vbyte_q[cnt_q] <= vf.mem_data; // [R17]
      end
    end
  end

  chk_brk_probe: assert property ( // [R13]
    @(posedge clk_i) disable iff (!rst_ni)
    (state_q == ivr_pkg::F_IDLE && vf.start && vf.brk_chk)
      |=> (rd_q && addr_q == ivr_pkg::BRK_MARK_ADDR))
    else $error("break probe not read first");

  chk_reloc_pick: assert property ( // [R13]
    @(posedge clk_i) disable iff (!rst_ni)
    (state_q == ivr_pkg::F_CHECK && pend_q && vf.mem_data == ivr_pkg::BRK_RELOC_MARK)
      |=> (rd_q && addr_q == $past(vf.reloc_base)))
    else $error("marked break did not use relocatable entry");

  chk_four_bytes: assert property ( // [R10]
    @(posedge clk_i) disable iff (!rst_ni)
    (state_q == ivr_pkg::F_IDLE && vf.start && !vf.brk_chk)
      |=> rd_q ##1 !rd_q ##1 rd_q ##1 !rd_q ##1 rd_q ##1 !rd_q ##1 rd_q ##1 !rd_q ##1 done_q)
    else $error("vector entry not read as four bytes");

endmodule // vector_fetch_unit
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================================================
  // signals
  logic        clk = 1'b0, rst_n = 1'b0, mark = 1'b0, wr = 1'b0, rd = 1'b0, swi = 1'b0;
  logic        ovf = 1'b0, iflag = 1'b0, preq = 1'b0, exv = 1'b0, uwr = 1'b0, uwd = 1'b0;
  logic        reti = 1'b0, retiu = 1'b0, ack, uflag, push, pushv, mrd, busy, pcl;
  logic [2:0]  addr = '0, trp = '0, lvl = '0, ipl = '0;
  logic [5:0]  sp = '0;
  logic [5:0]  swn = '0, pn = '0, n;
  logic [31:0] wd = '0, rdata;
  logic [19:0] exa = '0, base, maddr, pc;
  logic [7:0]  mdata;
  int          mismatches = 0, compares = 0, pushes = 0, p0 = 0;

  always #2.5 clk = ~clk;

  // a push adds one, and two more when the saved flag was set
  always @(negedge clk) begin
    if (push === 1'b1) pushes += (pushv === 1'b1) ? 3 : 1;
  end

  interrupt_vector_resolver dut_u (
    .CLOCK_I(clk), .NRST_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .SWI_REQ_I(swi), .SWI_NUM_I(swn),
    .UNDEFINED_OPCODE_OP_I(trp[0]), .OVERFLOW_TRAP_OP_I(trp[1]), .OVF_FLAG_I(ovf),
    .BREAK_OP_I(trp[2]), .WDOG_I(sp[0]), .OSC_STOP_I(sp[1]), .VMON1_I(sp[2]),
    .VMON2_I(sp[3]), .SSTEP_I(sp[4]), .ABREAK_I(sp[5]), .PER_REQ_I(preq), .PER_NUM_I(pn),
    .PER_LEVEL_I(lvl), .IFLAG_I(iflag), .IPL_I(ipl), .PER_ACK_O(ack), .EXEC_VALID_I(exv),
    .EXEC_ADDR_I(exa), .UFLAG_WR_I(uwr), .UFLAG_WDATA_I(uwd), .RETI_I(reti),
    .RETI_UFLAG_I(retiu), .UFLAG_O(uflag), .UFLAG_PUSH_O(push), .UFLAG_PUSH_VAL_O(pushv),
    .MEM_RD_O(mrd), .MEM_ADDR_O(maddr), .MEM_DATA_I(mdata), .BUSY_O(busy),
    .PC_LOAD_O(pcl), .PC_O(pc)
  );
  vec_mem_model mem_u (.clk_i(clk), .mem_rd_i(mrd), .mem_addr_i(maddr),
                       .brk_mark_i(mark), .mem_data_o(mdata));

  // ==========================================================================
  // expectations and bus tasks
  function automatic logic [7:0] vb(input logic [19:0] a);
    return (a == ivr_pkg::BRK_MARK_ADDR) ? {8{mark}} : a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  function automatic logic [19:0] vpc(input logic [19:0] a);
    logic [7:0] hi;
    hi = vb(a + 20'h2);
    return {hi[3:0], vb(a + 20'h1), vb(a)};
  endfunction
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic clr();
    @(posedge clk);
    {wr, rd, swi, trp, sp, exv, uwr, reti} <= '0;
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [19:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= {12'h0, d};
    clr();
  endtask
  task automatic reg_rd(input logic [2:0] a, input logic [19:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    clr();
    @(negedge clk);
    chk(rdata[19:0], exp);
  endtask
  // waits a bounded span for the handoff, then checks target and flag
  task automatic go(input logic [19:0] a, input logic u);
    repeat (40) begin
      @(negedge clk);
      if (pcl === 1'b1) break;
    end
    chk({19'h0, pcl}, 20'h1);
    chk(pc, vpc(a));
    chk({19'h0, uflag}, {19'h0, u});
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end

  // ==========================================================================
  // scenarios
  initial begin
    void'($urandom(32'h455d));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    base = 20'($urandom());
    reg_wr(ivr_pkg::REG_VEC_BASE, base);
    reg_rd(ivr_pkg::REG_VEC_BASE, base);
    for (int i = 0; i < 10; i++) begin
      n = (i == 0) ? 6'd32 : (i == 9) ? 6'd31 : 6'($urandom());
      p0 = pushes;
      @(posedge clk);
      uwr <= 1'b1;
      uwd <= 1'b1;
      clr();
      @(posedge clk);
      swi <= 1'b1;
      swn <= n;
      clr();
      go(base + 20'({n, 2'b00}), n > 6'd31);
      chk(20'(pushes - p0), (n > 6'd31) ? 20'h0 : 20'h3);
    end
    @(posedge clk);
    reti <= 1'b1;
    retiu <= 1'b1;
    clr();
    @(negedge clk);
    chk({19'h0, uflag}, 20'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      mark <= i[0];
      ovf <= 1'b1;
      trp <= (i < 2) ? 3'(1 << i) : 3'b100;
      clr();
      go((i == 0) ? ivr_pkg::VEC_UNDEF : (i == 1) ? ivr_pkg::VEC_OVF :
         (i == 3) ? base : ivr_pkg::VEC_BREAK, 1'b0);
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      sp <= 6'(1 << i);  // debug sources raised only as a tool would
      clr();
      go((i == 4) ? ivr_pkg::VEC_SSTEP : (i == 5) ? ivr_pkg::VEC_ABREAK :
         ivr_pkg::VEC_SPECIAL, 1'b0);
    end
    for (int c = 0; c < 2; c++) begin
      @(posedge clk);
      exa <= 20'($urandom());
      @(posedge clk);
      reg_wr(c ? ivr_pkg::REG_MATCH1 : ivr_pkg::REG_MATCH0, exa);
      reg_wr(ivr_pkg::REG_MATCH_EN, 20'(1 << c));
      @(posedge clk);
      exv <= 1'b1;
      clr();
      go(ivr_pkg::VEC_AMATCH, 1'b0);
    end
    reg_wr(ivr_pkg::REG_MATCH_EN, 20'h0);
    @(posedge clk);
    pn <= 6'($urandom_range(31, 3));
    preq <= 1'b1;
    lvl <= 3'h5;
    ipl <= 3'h2;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({19'h0, busy}, 20'h0);
    @(posedge clk);
    iflag <= 1'b1;
    repeat (8) begin
      @(negedge clk);
      if (ack === 1'b1) break;
    end
    chk({19'h0, ack}, 20'h1);
    @(posedge clk);
    preq <= 1'b0;
    go(base + 20'({pn, 2'b00}), 1'b0);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire

// [testbench/vec_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// vector memory, one cycle read latency
module vec_mem_model (
  // clock
  input  wire logic        clk_i,
  // read request
  input  wire logic        mem_rd_i,
  input  wire logic [19:0] mem_addr_i,
  input  wire logic        brk_mark_i,
  // read data
  output var logic  [7:0]  mem_data_o
);
  initial mem_data_o = 8'h00;
  // data stand only after a read; otherwise they toggle so stale bytes never pass
  always @(posedge clk_i) begin
    if (mem_rd_i) begin
      mem_data_o <= (mem_addr_i == ivr_pkg::BRK_MARK_ADDR) ? {8{brk_mark_i}} :
                    mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h3c;
    end else begin
      mem_data_o <= ~mem_data_o;
    end
  end
endmodule // vec_mem_model
`default_nettype wire
